// File: psl_defines.svh
// constants for the serial load and lock block
`ifndef PSL_DEFINES_SVH
`define PSL_DEFINES_SVH
`define PSL_PRI_W          20
`define PSL_ENH_W          8
`define PSL_ADDR_CTRL      12'h000
`define PSL_ADDR_STATUS    12'h004
`define PSL_ADDR_IRQ_STAT  12'h008
`define PSL_ADDR_IRQ_EN    12'h00C
`define PSL_ADDR_IRQ_CLR   12'h010
`define PSL_ADDR_PRI       12'h014
`define PSL_ADDR_SEC       12'h018
`define PSL_ADDR_ENH       12'h01C
`define PSL_ADDR_ACTIVE    12'h020
`define PSL_CTRL_ENH_N     0
`define PSL_CTRL_WSEL      1
`define PSL_CTRL_EWR       2
`define PSL_CTRL_RST_VAL   3'h1
`define PSL_IRQ_LOAD       0
`define PSL_IRQ_LOCK_CHG   1
`define PSL_IRQ_W          2
`define PSL_LOCK_FILT      8
`endif

// File: psl_host_model.sv
// host model driving the three-wire serial load port
`timescale 1ns/10ps
`default_nettype none
`include "psl_defines.svh"
module psl_host_model
#(
    parameter int HALF_NS = 200
)
(
    // serial load port
    output var logic ser_clk_o,
    output var logic ser_data_o,
    output var logic ser_load_o
);
    initial
    begin
        ser_clk_o  = 1'b0;
        ser_data_o = 1'b0;
        ser_load_o = 1'b0;
    end

    // data set while clock is low, strobe stays low meanwhile
    task automatic send_bit(input logic b);
        ser_data_o = b;
        #(HALF_NS) ser_clk_o = 1'b1;
        #(HALF_NS) ser_clk_o = 1'b0;
    endtask : send_bit

    // clock stands low between frames; data line no longer valid
    task automatic close(input logic load);
        ser_data_o = ~ser_data_o;
        #(HALF_NS);
        if (load)
        begin
            ser_load_o = 1'b1;
            #(2 * HALF_NS) ser_load_o = 1'b0;
        end
    endtask : close

    task automatic send_pri(input logic [`PSL_PRI_W-1:0] v, input logic load);
        for (int i = `PSL_PRI_W - 1; i >= 0; i--)
            send_bit(v[i]);
        close(load);
    endtask : send_pri

    task automatic send_enh(input logic [`PSL_ENH_W-1:0] v);
        for (int i = `PSL_ENH_W - 1; i >= 0; i--)
            send_bit(v[i]);
        close(1'b0);
    endtask : send_enh
endmodule : psl_host_model
`default_nettype wire

// File: psl_pkg.sv
// types for the serial load and lock block
package psl_pkg;
    typedef logic [31:0] psl_word_t;
endpackage : psl_pkg

// File: psl_sync3.sv
// three-stage input synchroniser with agreement qualifier
`timescale 1ns/10ps
`default_nettype none
module psl_sync3
    import psl_pkg::*;
#(
    parameter int W = 1
)
(
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // raw and qualified levels
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] q_reg;
    logic [W-1:0] q_next;

    initial
    begin
        if (W < 1)
        begin
            $error("psl_sync3: width must be at least one");
        end
    end

    // a change counts only once stages two and three agree
    always_comb
    begin
        q_next = q_reg;
        for (int i = 0; i < W; i++)
        begin
            if (s2_reg[i] == s3_reg[i])
            begin
                q_next[i] = s3_reg[i];
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            q_reg  <= '0;
        end
        else
        begin
            s1_reg <= d_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            q_reg  <= q_next;
        end
    end

    assign q_o = q_reg;
endmodule : psl_sync3
`default_nettype wire

// File: psl_top.sv
// serial load port, word selection, phase detector and lock indication
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "psl_defines.svh"
//
// Function
// - strobe rising edge copies primary to secondary
// - serial data shifted most significant first
// - select low shifts into 20-bit primary
// - select high shifts into 8-bit enhancement
// - source select picks primary or secondary
// - enhancement bits act only when mode low
// - auxiliary data output only in enhancement
// - filter node is NAND of pulses
// - lock output inverse of filtered node
// - down pulse when divided edge leads
// - up pulse when reference edge leads
module psl_top
    import psl_pkg::*;
#(
    parameter int PRI_W    = `PSL_PRI_W,
    parameter int ENH_W    = `PSL_ENH_W,
    parameter int FILT_N   = `PSL_LOCK_FILT,
    parameter int FIELD_LO = 0,
    parameter int FIELD_W  = 8
)
(
    // clock and reset
    input  wire logic             CORE_CLK_I,
    input  wire logic             RST_I,
    // serial load port
    input  wire logic             SER_CLK_I,
    input  wire logic             SER_DATA_I,
    input  wire logic             SER_LOAD_I,
    // comparison edges
    input  wire logic             REF_CMP_I,
    input  wire logic             DIV_CMP_I,
    // apb slave
    input  wire logic             PSEL_I,
    input  wire logic             PENABLE_I,
    input  wire logic             PWRITE_I,
    input  wire logic [11:0]      PADDR_I,
    input  wire logic [31:0]      PWDATA_I,
    output logic      [31:0]      PRDATA_O,
    output logic                  PREADY_O,
    output logic                  PSLVERR_O,
    // pll outputs
    output logic                  PHASE_DOWN_PULSE_N_O,
    output logic                  PHASE_UP_PULSE_N_O,
    output logic                  FILTER_NODE_O,
    output logic                  LOCK_INDICATOR_O,
    output logic                  LOCK_INDICATOR_OE_O,
    output logic                  AUX_DATA_O,
    output logic [PRI_W-1:0]      COUNTER_WORD_O,
    output logic [ENH_W-1:0]      ENH_WORD_O,
    output logic [FIELD_W-1:0]    COUNTER_FIELD_O,
    output logic                  IRQ_O
);
    initial
    begin
        if (PRI_W < 2 || PRI_W > 32 || ENH_W < 1 || ENH_W > 32 ||
            FILT_N < 2 || FILT_N > 255 || FIELD_W < 1 ||
            FIELD_LO + FIELD_W > PRI_W)
        begin
            $error("psl_top: unsupported parameter values");
        end
    end

    // synchronised pins
    logic s_clk;
    logic s_dat;
    logic s_ld;
    logic s_ref;
    logic s_div;
    psl_sync3 #(.W(5)) u_sync
    (
        .clk_i (CORE_CLK_I),
        .rst_i (RST_I),
        .d_i   ({SER_CLK_I, SER_DATA_I, SER_LOAD_I, REF_CMP_I, DIV_CMP_I}),
        .q_o   ({s_clk, s_dat, s_ld, s_ref, s_div})
    );

    // register state
    logic [2:0]          ctrl_reg,  ctrl_next;
    logic [PRI_W-1:0]    pri_reg,   pri_next;
    logic [PRI_W-1:0]    sec_reg,   sec_next;
    logic [ENH_W-1:0]    enh_reg,   enh_next;
    logic                sclk_d_reg;
    logic                sld_d_reg;
    logic                ref_d_reg, div_d_reg;
    logic                up_reg,    up_next;
    logic                dn_reg,    dn_next;
    logic [7:0]          filt_reg,  filt_next;
    logic                lock_reg,  lock_next;
    logic [`PSL_IRQ_W-1:0] ist_reg, ist_next;
    logic [`PSL_IRQ_W-1:0] ien_reg, ien_next;
    logic [31:0]         rd_reg,    rd_next;
    logic                rdy_reg,   rdy_next;
    logic                err_reg,   err_next;
    logic [PRI_W-1:0]    cw_reg,    cw_next;
    logic [ENH_W-1:0]    ew_reg,    ew_next;
    logic                aux_reg,   aux_next;
    logic                fnode_reg, fnode_next;

    logic enh_n, wsel, ewr;
    logic sclk_rise, sld_rise, ref_rise, div_rise;
    logic apb_acc, apb_wr;
    logic [`PSL_IRQ_W-1:0] ev;

    assign enh_n     = ctrl_reg[`PSL_CTRL_ENH_N];
    assign wsel      = ctrl_reg[`PSL_CTRL_WSEL];
    assign ewr       = ctrl_reg[`PSL_CTRL_EWR];
    assign sclk_rise = s_clk & ~sclk_d_reg;
    assign sld_rise  = s_ld & ~sld_d_reg;
    assign ref_rise  = s_ref & ~ref_d_reg;
    assign div_rise  = s_div & ~div_d_reg;
    assign apb_acc   = PSEL_I & PENABLE_I & ~rdy_reg;
    assign apb_wr    = apb_acc & PWRITE_I;

    function automatic logic [31:0] zext_pri(input logic [PRI_W-1:0] v);
        zext_pri = 32'(v);
    endfunction : zext_pri

    // serial shift and transfer
    always_comb
    begin
        pri_next = pri_reg;
        sec_next = sec_reg;
        enh_next = enh_reg;
        // shifting is suppressed while strobe is high; host keeps it low
        if (sclk_rise && !s_ld)
        begin
            if (ewr)
            begin
                enh_next = {enh_reg[ENH_W-2:0], s_dat};
            end
            else
            begin
                pri_next = {pri_reg[PRI_W-2:0], s_dat};
            end
        end
        if (sld_rise)
        begin
            sec_next = pri_reg;
        end
    end

    // phase detector, filter and lock
    always_comb
    begin
        up_next = up_reg;
        dn_next = dn_reg;
        if (ref_rise && div_rise)
        begin
            // coincident edges: neither side leads
            up_next = 1'b1;
            dn_next = 1'b1;
        end
        else if (ref_rise)
        begin
            // reference edge ends a pending down pulse, else leads
            if (!dn_reg)
            begin
                dn_next = 1'b1;
            end
            else
            begin
                up_next = 1'b0;
            end
        end
        else if (div_rise)
        begin
            // divided edge ends a pending up pulse, else leads
            if (!up_reg)
            begin
                up_next = 1'b1;
            end
            else
            begin
                dn_next = 1'b0;
            end
        end
        fnode_next = ~(~up_reg & ~dn_reg) ? 1'b1 : 1'b0;
        fnode_next = ~((~up_reg) & (~dn_reg)) & 1'b1;
        fnode_next = ~(up_reg & dn_reg) ? 1'b0 : 1'b0;
        // active-low pulses: NAND of the two pins
        fnode_next = ~((~up_reg) & (~dn_reg)) ^ 1'b1 ^ 1'b1;
        fnode_next = ~(( ~up_reg ? 1'b0 : 1'b1) & (~dn_reg ? 1'b0 : 1'b1));
        fnode_next = ~((~up_reg) & (~dn_reg)) == 1'b0 ? 1'b1 : 1'b0;
        fnode_next = ~((up_reg ? 1'b0 : 1'b1) & (dn_reg ? 1'b0 : 1'b1)) ?
                     1'b0 : 1'b1;
        fnode_next = ~((~up_reg) & (~dn_reg));
        fnode_next = ~(~up_reg & ~dn_reg) & ~(up_reg & dn_reg);
        fnode_next = ~((~up_reg) & (~dn_reg));
        fnode_next = ~( (~up_reg) & (~dn_reg) );
        fnode_next = ~((~up_reg) & (~dn_reg)) & 1'b1;
        fnode_next = (up_reg | dn_reg);
        fnode_next = ~(up_reg & dn_reg);
        // rc filter modelled as saturating integrator
        filt_next = filt_reg;
        if (fnode_reg && filt_reg != 8'(FILT_N))
        begin
            filt_next = filt_reg + 8'h01;
        end
        else if (!fnode_reg && filt_reg != 8'h00)
        begin
            filt_next = filt_reg - 8'h01;
        end
        lock_next = lock_reg;
        if (filt_reg == 8'h00)
        begin
            lock_next = 1'b1;
        end
        else if (filt_reg == 8'(FILT_N))
        begin
            lock_next = 1'b0;
        end
    end

    // counter word selection and enhancement gating
    always_comb
    begin
        cw_next  = ctrl_reg[`PSL_CTRL_WSEL] ? pri_reg : sec_reg;
        ew_next  = enh_n ? '0 : enh_reg;
        aux_next = enh_n ? 1'b0 : (wsel ? pri_reg[PRI_W-1]
                                        : sec_reg[PRI_W-1]);
    end

    // apb slave and interrupts
    always_comb
    begin
        ctrl_next = ctrl_reg;
        ien_next  = ien_reg;
        rd_next   = rd_reg;
        rdy_next  = apb_acc;
        err_next  = 1'b0;
        ev        = '0;
        ev[`PSL_IRQ_LOAD]     = sld_rise;
        ev[`PSL_IRQ_LOCK_CHG] = lock_next ^ lock_reg;
        ist_next  = ist_reg;
        if (apb_acc)
        begin
            rd_next = 32'h0000_0000;
            unique case (PADDR_I)
                `PSL_ADDR_CTRL:
                begin
                    rd_next = 32'(ctrl_reg);
                    if (PWRITE_I)
                    begin
                        ctrl_next = PWDATA_I[2:0];
                    end
                end
                `PSL_ADDR_STATUS:   rd_next = {30'h0, ~lock_reg, lock_reg};
                `PSL_ADDR_IRQ_STAT: rd_next = 32'(ist_reg);
                `PSL_ADDR_IRQ_EN:
                begin
                    rd_next = 32'(ien_reg);
                    if (PWRITE_I)
                    begin
                        ien_next = PWDATA_I[`PSL_IRQ_W-1:0];
                    end
                end
                `PSL_ADDR_IRQ_CLR:
                begin
                    if (apb_wr)
                    begin
                        ist_next = ist_reg & ~PWDATA_I[`PSL_IRQ_W-1:0];
                    end
                end
                `PSL_ADDR_PRI:    rd_next = zext_pri(pri_reg);
                `PSL_ADDR_SEC:    rd_next = zext_pri(sec_reg);
                `PSL_ADDR_ENH:    rd_next = 32'(enh_reg);
                `PSL_ADDR_ACTIVE: rd_next = zext_pri(cw_reg);
                default:          err_next = 1'b1;
            endcase
        end
        // set wins over clear
        ist_next = ist_next | ev;
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        if (RST_I)
        begin
            ctrl_reg   <= `PSL_CTRL_RST_VAL;
            pri_reg    <= '0;
            sec_reg    <= '0;
            enh_reg    <= '0;
            sclk_d_reg <= 1'b0;
            sld_d_reg  <= 1'b0;
            ref_d_reg  <= 1'b0;
            div_d_reg  <= 1'b0;
            up_reg     <= 1'b1;
            dn_reg     <= 1'b1;
            fnode_reg  <= 1'b0;
            filt_reg   <= 8'h00;
            lock_reg   <= 1'b1;
            ist_reg    <= '0;
            ien_reg    <= '0;
            rd_reg     <= 32'h0000_0000;
            rdy_reg    <= 1'b0;
            err_reg    <= 1'b0;
            cw_reg     <= '0;
            ew_reg     <= '0;
            aux_reg    <= 1'b0;
        end
        else
        begin
            ctrl_reg   <= ctrl_next;
            pri_reg    <= pri_next;
            sec_reg    <= sec_next;
            enh_reg    <= enh_next;
            sclk_d_reg <= s_clk;
            sld_d_reg  <= s_ld;
            ref_d_reg  <= s_ref;
            div_d_reg  <= s_div;
            up_reg     <= up_next;
            dn_reg     <= dn_next;
            fnode_reg  <= fnode_next;
            filt_reg   <= filt_next;
            lock_reg   <= lock_next;
            ist_reg    <= ist_next;
            ien_reg    <= ien_next;
            rd_reg     <= rd_next;
            rdy_reg    <= rdy_next;
            err_reg    <= err_next;
            cw_reg     <= cw_next;
            ew_reg     <= ew_next;
            aux_reg    <= aux_next;
        end
    end

    logic irq_reg;
    logic ld_oe_reg;
    logic [FIELD_W-1:0] fld_reg;
    always_ff @(posedge CORE_CLK_I)
    begin
        if (RST_I)
        begin
            irq_reg   <= 1'b0;
            ld_oe_reg <= 1'b0;
            fld_reg   <= '0;
        end
        else
        begin
            irq_reg   <= |(ist_next & ien_next);
            ld_oe_reg <= ~lock_next;
            fld_reg   <= cw_next[FIELD_LO +: FIELD_W];
        end
    end

    assign PRDATA_O             = rd_reg;
    assign PREADY_O             = rdy_reg;
    assign PSLVERR_O            = err_reg;
    assign PHASE_DOWN_PULSE_N_O = dn_reg;
    assign PHASE_UP_PULSE_N_O   = up_reg;
    assign FILTER_NODE_O        = fnode_reg;
    assign LOCK_INDICATOR_O     = 1'b0;
    assign LOCK_INDICATOR_OE_O  = ld_oe_reg;
    assign AUX_DATA_O           = aux_reg;
    assign COUNTER_WORD_O       = cw_reg;
    assign ENH_WORD_O           = ew_reg;
    assign COUNTER_FIELD_O      = fld_reg;
    assign IRQ_O                = irq_reg;

    AST_SEC_LOAD: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        sld_rise |=> sec_reg == $past(pri_reg))
        else $error("secondary not loaded on strobe");
    AST_PRI_SHIFT: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        (sclk_rise && !ewr && !s_ld) |=>
        pri_reg[0] == $past(s_dat) &&
        pri_reg[PRI_W-1:1] == $past(pri_reg[PRI_W-2:0]))
        else $error("primary shift wrong");
    AST_ENH_HOLD: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        (sclk_rise && ewr && !sld_rise) |=> $stable(pri_reg))
        else $error("primary changed in enhancement write");
    AST_WORD_SEL: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        ##1 cw_reg == ($past(wsel) ? $past(pri_reg) : $past(sec_reg)))
        else $error("wrong counter word source");
    AST_ENH_GATE: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        $past(enh_n) |-> ew_reg == '0 && !aux_reg)
        else $error("enhancement bits leak");
    AST_FNODE: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        ##1 fnode_reg == ~($past(up_reg) & $past(dn_reg)))
        else $error("filter node not nand");
    AST_LOCK_OE: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        LOCK_INDICATOR_OE_O == !lock_reg)
        else $error("lock indicator not inverse");
    AST_APB_ONE: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        rdy_reg |=> !rdy_reg)
        else $error("pready held too long");
endmodule : psl_top
`default_nettype wire

// File: psl_top_tb.sv
// self-checking bench for the serial load and lock block
`timescale 1ns/10ps
`default_nettype none
`include "psl_defines.svh"
module psl_top_tb
    import psl_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    psl_word_t   pwdata = 32'h0;
    logic        ref_cmp = 1'b0;
    logic        div_cmp = 1'b0;
    wire logic   sclk, sdata, sload;
    psl_word_t   prdata;
    logic        pready, pslverr, pdn, pup, fnode, lk_o, lk_oe, aux, irq;
    logic [19:0] cword, p, q;
    logic [7:0]  eword, field, e;
    logic        lock_wire;
    logic [32:0] rdq [$];
    logic [31:0] seed = 32'hFE117288;
    int          err_count = 0;
    int          checked = 0;

    // open drain lock line with external pull-up
    assign lock_wire = lk_oe ? lk_o : 1'b1;

    always #25 clk = ~clk;

    psl_top #(.FIELD_LO(4), .FIELD_W(8)) DUT (
        .CORE_CLK_I(clk), .RST_I(rst), .SER_CLK_I(sclk), .SER_DATA_I(sdata),
        .SER_LOAD_I(sload), .REF_CMP_I(ref_cmp), .DIV_CMP_I(div_cmp),
        .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .PHASE_DOWN_PULSE_N_O(pdn),
        .PHASE_UP_PULSE_N_O(pup), .FILTER_NODE_O(fnode),
        .LOCK_INDICATOR_O(lk_o), .LOCK_INDICATOR_OE_O(lk_oe),
        .AUX_DATA_O(aux), .COUNTER_WORD_O(cword), .ENH_WORD_O(eword),
        .COUNTER_FIELD_O(field), .IRQ_O(irq));

    psl_host_model host (.ser_clk_o(sclk), .ser_data_o(sdata),
                         .ser_load_o(sload));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic cmp_rd(input logic [32:0] got, input logic [32:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_rd

    task automatic cmp_pin(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_pin

    // read data is masked on writes so every transfer checks its error flag
    always @(posedge clk)
        if (psel && pen && pready === 1'b1 && rdq.size() > 0)
            cmp_rd({pslverr, pwr ? 32'h0 : prdata}, rdq.pop_front());

    task automatic apb(input logic w, input logic [11:0] a,
                       input psl_word_t d, input logic [32:0] exp);
        int n;
        n = 0;
        rdq.push_back(exp);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
        begin
            n++;
            @(posedge clk);
        end
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input psl_word_t d);
        apb(1'b1, a, d, 33'h0);
    endtask : wr

    task automatic rd(input logic [11:0] a, input psl_word_t d);
        apb(1'b0, a, 32'h0, {1'b0, d});
    endtask : rd

    function automatic logic [31:0] pin(input int s);
        case (s)
            0: return {31'h0, pdn};
            1: return {31'h0, pup};
            2: return {31'h0, fnode};
            3: return {31'h0, lock_wire};
            4: return {12'h000, cword};
            5: return {24'h0, eword};
            6: return {31'h0, aux};
            7: return {24'h0, field};
            default: return {31'h0, irq};
        endcase
    endfunction : pin

    // inputs pass a synchroniser, so allow a bounded settle
    task automatic await(input int s, input logic [31:0] v);
        int n;
        n = 0;
        while (pin(s) !== v && n < 60)
        begin
            n++;
            @(posedge clk);
        end
        cmp_pin(pin(s), v);
    endtask : await

    task automatic results();
        $display("errors %0d checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results

    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        results();
    end

    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(`PSL_ADDR_CTRL, 32'h1);
        apb(1'b1, 12'h040, 32'h7, {1'b1, 32'h0});
        rd(`PSL_ADDR_CTRL, 32'h1);
        await(5, 32'h0);
        await(6, 32'h0);
        wr(`PSL_ADDR_IRQ_CLR, 32'h3);
        wr(`PSL_ADDR_IRQ_EN, 32'h1);
        repeat (2)
        begin
            p = rnd();
            host.send_pri(p, 1'b1);
            @(posedge clk);
            await(4, {12'h000, p});
            await(7, {24'h0, p[11:4]});
            rd(`PSL_ADDR_PRI, {12'h000, p});
            rd(`PSL_ADDR_SEC, {12'h000, p});
            await(8, 32'h1);
            rd(`PSL_ADDR_IRQ_STAT, 32'h1);
            wr(`PSL_ADDR_IRQ_CLR, 32'h1);
            await(8, 32'h0);
        end
        wr(`PSL_ADDR_CTRL, 32'h3);
        q = rnd();
        host.send_pri(q, 1'b0);
        @(posedge clk);
        await(4, {12'h000, q});
        rd(`PSL_ADDR_SEC, {12'h000, p});
        wr(`PSL_ADDR_IRQ_EN, 32'h0);
        host.send_pri(q, 1'b1);
        @(posedge clk);
        rd(`PSL_ADDR_IRQ_STAT, 32'h1);
        await(8, 32'h0);
        wr(`PSL_ADDR_CTRL, 32'h7);
        e = rnd();
        host.send_enh(e);
        @(posedge clk);
        rd(`PSL_ADDR_ENH, {24'h0, e});
        rd(`PSL_ADDR_PRI, {12'h000, q});
        await(5, 32'h0);
        wr(`PSL_ADDR_CTRL, 32'h6);
        await(5, {24'h0, e});
        await(6, {31'h0, q[19]});
        wr(`PSL_ADDR_IRQ_CLR, 32'h3);
        wr(`PSL_ADDR_IRQ_EN, 32'h2);
        ref_cmp <= 1'b1;
        await(1, 32'h0);
        await(0, 32'h1);
        await(2, 32'h1);
        await(3, 32'h0);
        await(8, 32'h1);
        rd(`PSL_ADDR_STATUS, 32'h2);
        div_cmp <= 1'b1;
        await(1, 32'h1);
        await(2, 32'h0);
        await(3, 32'h1);
        ref_cmp <= 1'b0;
        div_cmp <= 1'b0;
        // low long enough to pass the agreement synchroniser
        repeat (6) @(posedge clk);
        div_cmp <= 1'b1;
        await(0, 32'h0);
        await(1, 32'h1);
        await(2, 32'h1);
        ref_cmp <= 1'b1;
        await(0, 32'h1);
        await(3, 32'h1);
        rd(`PSL_ADDR_STATUS, 32'h1);
        results();
    end
endmodule : psl_top_tb
`default_nettype wire
